// ===== hdl/rac_pkg.sv
// Operation
// [RQ1] bit 6 pulses loop filter clear
// [RQ2] bit 5 pulses comb-integrator filter clear
// [RQ3] bit 3 resets auto sync logic
// [RQ4] bit 2 resets tuning word history
// [RQ5] bit 1 clears every monitor bit
// [RQ6] bit 0 restarts watchdog, no timeout
// [RQ7] expired watchdog restarts new cycle
// [RQ8] clear bit resets matching monitor bit
// [RQ9] clear registers self-clear after one use
// [RQ10] clear bit n acts on monitor n
// [RQ11] 0xa04: system clock and pll clears
// [RQ12] 0xa05: sync, watchdog, nvm clears
// [RQ13] 0xa06: dpll state clears, eight bits
// [RQ14] 0xa07: history and limiter clears
// [RQ15] 0xa08: reference input clears, 7/3 reserved
// [RQ16] zero writes inert, all read zero
package rac_pkg;

  // ----------------------------------------
  // register indices, byte address = 4 * index
  // ----------------------------------------
  localparam int IDX_W = 12;
  localparam logic [IDX_W-1:0] IDX_RESET_ACTIONS = 12'ha03;
  localparam logic [IDX_W-1:0] IDX_CLR_SYS = 12'ha04;
  localparam logic [IDX_W-1:0] IDX_CLR_SYNC = 12'ha05;
  localparam logic [IDX_W-1:0] IDX_CLR_DPLL = 12'ha06;
  localparam logic [IDX_W-1:0] IDX_CLR_HIST = 12'ha07;
  localparam logic [IDX_W-1:0] IDX_CLR_REFS = 12'ha08;
  localparam logic [IDX_W-1:0] IDX_CLR_SPARE = 12'ha09;
  localparam logic [IDX_W-1:0] IDX_MON_BASE = 12'ha14;
  localparam logic [IDX_W-1:0] IDX_WDOG_STAT = 12'ha19;

  // ----------------------------------------
  // reset-action bit positions
  // ----------------------------------------
  localparam int RA_LOOP_FILTER = 6;
  localparam int RA_COMB = 5;
  localparam int RA_AUTO_SYNC = 3;
  localparam int RA_TW_HIST = 2;
  localparam int RA_CLR_ALL = 1;
  localparam int RA_WDOG = 0;

  // ----------------------------------------
  // monitor groups and implemented bits
  // ----------------------------------------
  localparam int NUM_GROUPS = 5;
  localparam int IRQ_W = 8 * NUM_GROUPS;
  localparam logic [7:0] MASK_SYS = 8'h3f;
  localparam logic [7:0] MASK_SYNC = 8'h1f;
  localparam logic [7:0] MASK_DPLL = 8'hff;
  localparam logic [7:0] MASK_HIST = 8'h1f;
  localparam logic [7:0] MASK_REFS = 8'h77;
  localparam int WDOG_IRQ_BIT = 2;
  localparam logic [7:0] WB_ZERO = 8'h00;

  typedef struct packed {
    logic [7:0] refs;
    logic [7:0] hist;
    logic [7:0] dpll;
    logic [7:0] sync;
    logic [7:0] sys;
  } rac_irq_vec_t;

  typedef struct packed {
    logic loop_filter;
    logic comb;
    logic auto_sync;
    logic tw_hist;
  } rac_pulse_t;

endpackage : rac_pkg

// ===== hdl/rac_watchdog.sv
`timescale 1ns/1ps
module rac_watchdog #(
  parameter int PERIOD_CYC = 1000
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic restart_i,
  // status
  output logic timeout_o,
  output logic expired_o
);

  localparam int CNT_W = $clog2(PERIOD_CYC + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD_CYC - 1);

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic tmo_q, tmo_d;
  logic exp_q, exp_d;

  always_comb
  begin
    cnt_d = cnt_q + CNT_W'(1);
    tmo_d = 1'b0;
    exp_d = exp_q;
    // [RQ6] [RQ7] restart from zero
    if (restart_i)
    begin
      cnt_d = '0;
      exp_d = 1'b0;
    end
    else if (cnt_q == LAST)
    begin
      // expiry starts a new timing cycle
      cnt_d = '0;
      tmo_d = 1'b1;
      exp_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q <= '0;
      tmo_q <= 1'b0;
      exp_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tmo_q <= tmo_d;
      exp_q <= exp_d;
    end
  end

  assign timeout_o = tmo_q;
  assign expired_o = exp_q;

endmodule : rac_watchdog

// ===== hdl/rac_ctrl.sv
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
module rac_ctrl #(
  parameter int WDOG_CYC = 1000
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // event sources, same clock
  input rac_pkg::rac_irq_vec_t irq_event_i,
  // monitor bits
  output rac_pkg::rac_irq_vec_t irq_monitor_o,
  // reset action strobes
  output logic loop_filter_clear_o,
  output logic comb_integrator_filter_clear_o,
  output logic auto_sync_clear_o,
  output logic tuning_word_history_clear_o,
  // watchdog state
  output logic watchdog_expired_o
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam logic [rac_pkg::IRQ_W-1:0] VALID = {
    rac_pkg::MASK_REFS,
    rac_pkg::MASK_HIST,
    rac_pkg::MASK_DPLL,
    rac_pkg::MASK_SYNC,
    rac_pkg::MASK_SYS
  };

  logic req;
  logic wr_fire;
  logic [rac_pkg::IDX_W-1:0] idx;
  logic [7:0] wbyte;
  logic hit_ra;
  logic [rac_pkg::NUM_GROUPS-1:0] grp_clr_hit;
  logic [rac_pkg::NUM_GROUPS-1:0] grp_mon_hit;
  logic [rac_pkg::IRQ_W-1:0] grp_clr_vec;
  logic [rac_pkg::NUM_GROUPS-1:0][7:0] grp_rd_byte;
  logic [7:0] mon_rd_byte;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [rac_pkg::IRQ_W-1:0] clr_vec;
  logic [rac_pkg::IRQ_W-1:0] evt_vec;
  logic [rac_pkg::IRQ_W-1:0] mon_q, mon_d;
  rac_pkg::rac_pulse_t pls_q, pls_d;
  logic wd_restart;
  logic wd_timeout;
  logic wd_expired;
  logic wd_exp_q, wd_exp_d;
  logic [7:0] ra_byte;
  logic [7:0] rd_byte;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[rac_pkg::IDX_W+1:2];
  assign wbyte = wb_sel_i[0] ? wb_dat_i[7:0] : rac_pkg::WB_ZERO;
  // a write acts only at the edge where ack is seen
  assign wr_fire = req & wb_we_i & ack_q;
  assign hit_ra = (idx == rac_pkg::IDX_RESET_ACTIONS);
  assign ra_byte = (wr_fire && hit_ra) ? wbyte : rac_pkg::WB_ZERO;

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  always_comb
  begin
    // ack one cycle after the request, dropped after one
    ack_d = req & ~ack_q;
    dat_d = dat_q;
    if (req && !ack_q)
    begin
      dat_d = {24'h000000, rd_byte};
    end
    else if (!req)
    begin
      dat_d = '0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end
    else
    begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // ----------------------------------------
  // per-group decode
  // ----------------------------------------
  // clear row and monitor row list the groups in one order, so a
  // clear byte and a readback byte never meet the wrong group
  genvar gg;
  generate
    for (gg = 0; gg < rac_pkg::NUM_GROUPS; gg++)
    begin : g_grp
      // [RQ10] clear index g meets monitor byte g
      assign grp_clr_hit[gg] = (idx == rac_pkg::IDX_CLR_SYS + 12'(gg));
      assign grp_mon_hit[gg] = (idx == rac_pkg::IDX_MON_BASE + 12'(gg));
      assign grp_clr_vec[8 * gg +: 8] = (wr_fire && grp_clr_hit[gg]) ? wbyte :
                                        rac_pkg::WB_ZERO;
      assign grp_rd_byte[gg] = grp_mon_hit[gg] ? mon_q[8 * gg +: 8] : rac_pkg::WB_ZERO;
    end
  endgenerate

  always_comb
  begin
    // at most one group hits, so or-ing the bytes picks it
    mon_rd_byte = rac_pkg::WB_ZERO;
    for (int g = 0; g < rac_pkg::NUM_GROUPS; g++)
    begin
      mon_rd_byte = mon_rd_byte | grp_rd_byte[g];
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb
  begin
    rd_byte = rac_pkg::WB_ZERO;
    // [RQ16] command registers read zero
    if (|grp_mon_hit)
    begin
      rd_byte = mon_rd_byte;
    end
    else if (idx == rac_pkg::IDX_WDOG_STAT)
    begin
      rd_byte = {7'h00, wd_exp_q};
    end
  end

  // ----------------------------------------
  // reset action strobes
  // ----------------------------------------
  always_comb
  begin
    // [RQ9] strobes last one cycle only
    pls_d = '0;
    // [RQ1] loop filter clear
    pls_d.loop_filter = ra_byte[rac_pkg::RA_LOOP_FILTER];
    // [RQ2] comb filter clear
    pls_d.comb = ra_byte[rac_pkg::RA_COMB];
    // [RQ3] auto sync reset
    pls_d.auto_sync = ra_byte[rac_pkg::RA_AUTO_SYNC];
    // [RQ4] history reset
    pls_d.tw_hist = ra_byte[rac_pkg::RA_TW_HIST];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      pls_q <= '0;
    end
    else
    begin
      pls_q <= pls_d;
    end
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // [RQ6] restart on written one
  assign wd_restart = ra_byte[rac_pkg::RA_WDOG];

  rac_watchdog #(
    .PERIOD_CYC(WDOG_CYC)
  ) u_wdog (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .restart_i(wd_restart),
    .timeout_o(wd_timeout),
    .expired_o(wd_expired)
  );

  always_comb
  begin
    wd_exp_d = wd_expired;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      wd_exp_q <= 1'b0;
    end
    else
    begin
      wd_exp_q <= wd_exp_d;
    end
  end

  // ----------------------------------------
  // clear vector
  // ----------------------------------------
  always_comb
  begin
    // [RQ8] [RQ10] bit n clears monitor n
    // [RQ11] [RQ12] [RQ13] [RQ14] [RQ15] group select
    clr_vec = grp_clr_vec;
    // [RQ5] clear all monitors
    if (ra_byte[rac_pkg::RA_CLR_ALL])
    begin
      clr_vec = '1;
    end
    // reserved positions hold no monitor
    clr_vec = clr_vec & VALID;
  end

  // ----------------------------------------
  // event vector
  // ----------------------------------------
  always_comb
  begin
    evt_vec = irq_event_i;
    // watchdog expiry feeds its own monitor bit
    evt_vec[8 + rac_pkg::WDOG_IRQ_BIT] =
      irq_event_i.sync[rac_pkg::WDOG_IRQ_BIT] | wd_timeout;
  end

  // ----------------------------------------
  // monitor bits
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < rac_pkg::IRQ_W; gi++)
    begin : g_mon
      if (VALID[gi])
      begin : g_used
        // set wins over a clear in the same cycle
        always_comb
        begin
          mon_d[gi] = evt_vec[gi] | (mon_q[gi] & ~clr_vec[gi]);
        end
      end
      else
      begin : g_rsvd
        always_comb
        begin
          mon_d[gi] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      mon_q <= '0;
    end
    else
    begin
      mon_q <= mon_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq_monitor_o = mon_q;
  assign loop_filter_clear_o = pls_q.loop_filter;
  assign comb_integrator_filter_clear_o = pls_q.comb;
  assign auto_sync_clear_o = pls_q.auto_sync;
  assign tuning_word_history_clear_o = pls_q.tw_hist;
  assign watchdog_expired_o = wd_exp_q;

endmodule : rac_ctrl

// ===== testbench/rac_checker.sv
`timescale 1ns/1ps
module rac_checker #(
  parameter int WDOG_CYC = 1000
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input rac_pkg::rac_irq_vec_t irq_event_i,
  input rac_pkg::rac_irq_vec_t irq_monitor_o,
  input wire logic loop_filter_clear_o,
  input wire logic comb_integrator_filter_clear_o,
  input wire logic auto_sync_clear_o,
  input wire logic tuning_word_history_clear_o,
  input wire logic watchdog_expired_o
);
  // ----
  // write taken at the ack edge
  // ----
  logic wr;
  logic ra;
  logic [11:0] ix;
  assign ix = wb_adr_i[13:2];
  assign wr = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
  assign ra = wr & (ix == rac_pkg::IDX_RESET_ACTIONS);
  localparam logic [39:0] USED = {rac_pkg::MASK_REFS, rac_pkg::MASK_HIST, rac_pkg::MASK_DPLL,
    rac_pkg::MASK_SYNC, rac_pkg::MASK_SYS};
  logic pulse_any;
  assign pulse_any = loop_filter_clear_o | comb_integrator_filter_clear_o | auto_sync_clear_o |
    tuning_word_history_clear_o;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  lf_pulse_a: assert property (ra |=> loop_filter_clear_o == $past(wb_dat_i[6]))
    else $error("loop filter clear pulse wrong");
  comb_pulse_a: assert property (ra |=> comb_integrator_filter_clear_o == $past(wb_dat_i[5]))
    else $error("comb filter clear pulse wrong");
  sync_cause_a: assert property ($rose(auto_sync_clear_o) |-> $past(ra && wb_dat_i[3]))
    else $error("auto sync clear without cause");
  hist_once_a: assert property (ra && wb_dat_i[2] |=> tuning_word_history_clear_o ##1
    !tuning_word_history_clear_o) else $error("history clear not one pulse");
  clr_all_a: assert property (ra && wb_dat_i[1] && irq_event_i == '0 |=>
    irq_monitor_o.sys == 8'h00 && irq_monitor_o.dpll == 8'h00 &&
    irq_monitor_o.hist == 8'h00 && irq_monitor_o.refs == 8'h00 &&
    (irq_monitor_o.sync & ~(8'h01 << rac_pkg::WDOG_IRQ_BIT)) == 8'h00)
    else $error("clear all failed");
  clr_dpll_a: assert property (wr && ix == rac_pkg::IDX_CLR_DPLL && irq_event_i.dpll == 8'h00
    |=> (irq_monitor_o.dpll & $past(wb_dat_i[7:0])) == 8'h00) else $error("dpll clear failed");
  rsvd_zero_a: assert property ((irq_monitor_o & ~USED) == 40'h0)
    else $error("reserved monitor bit set");
  wdog_rst_a: assert property (ra && wb_dat_i[0] |-> ##2 !watchdog_expired_o)
    else $error("watchdog restart failed");
  rd_zero_a: assert property (wb_ack_o && !wb_we_i && ix == rac_pkg::IDX_RESET_ACTIONS
    |-> wb_dat_o == 32'h0) else $error("action register reads nonzero");
  strobe_len_a: assert property (pulse_any |=> !pulse_any)
    else $error("action strobe longer than one cycle");
  cover property (ra && wb_dat_i[1]);
  cover property (wr && ix == rac_pkg::IDX_CLR_DPLL && irq_event_i.dpll != 8'h00);
  cover property (wr && ix == rac_pkg::IDX_CLR_REFS);
  cover property ($rose(watchdog_expired_o));
endmodule : rac_checker

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int WCYC = 200;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  rac_pkg::rac_irq_vec_t irq_event_i = '0;
  rac_pkg::rac_irq_vec_t irq_monitor_o;
  logic loop_filter_clear_o;
  logic comb_integrator_filter_clear_o;
  logic auto_sync_clear_o;
  logic tuning_word_history_clear_o;
  logic watchdog_expired_o;
  logic [3:0] pv;
  int n_fail = 0;
  int n_checks = 0;
  assign pv = {loop_filter_clear_o, comb_integrator_filter_clear_o, auto_sync_clear_o,
    tuning_word_history_clear_o};
  // short watchdog period keeps the run brief
  rac_ctrl #(.WDOG_CYC(WCYC)) u_rac_ctrl (.*);
  initial
  begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] s);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // ----
  // classic cycle, held until ack sampled
  // ----
  task automatic wb(input logic we, input logic [11:0] ix, input logic [7:0] d,
    input logic s0, output logic [7:0] q);
    int i;
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {2'b00, ix, 2'b00};
    wb_sel_i <= {3'b000, s0};
    wb_dat_i <= {24'h0, d};
    i = 0;
    do
    begin
      @(posedge sys_clk_i);
      i++;
    end
    while (wb_ack_o !== 1'b1 && i < 50);
    if (wb_ack_o !== 1'b1)
    begin
      n_fail++;
      stop_test();
    end
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb
  task automatic t_actions();
    logic [7:0] r;
    int b[4] = '{6, 5, 3, 2};
    for (int k = 0; k < 4; k++)
    begin
      wb(1'b1, rac_pkg::IDX_RESET_ACTIONS, 8'h01 << b[k], 1'b1, r);
      #1 chk("pulse", 40'(4'b1000 >> k), 40'(pv));
      @(posedge sys_clk_i);
      #1 chk("pulse end", 40'h0, 40'(pv));
    end
    wb(1'b1, rac_pkg::IDX_RESET_ACTIONS, 8'h00, 1'b1, r);
    #1 chk("zero write", 40'h0, 40'(pv));
    // unmapped index last
    for (int k = 0; k < 8; k++)
    begin
      wb(1'b0, (k == 7) ? 12'hb00 : rac_pkg::IDX_RESET_ACTIONS + 12'(k), 8'h00, 1'b1, r);
      chk("read", 40'h0, 40'(r));
    end
    $display("actions done");
  endtask : t_actions
  task automatic t_irq();
    logic [7:0] r;
    logic [39:0] e;
    logic [7:0] p;
    // restart first so no timeout lands mid-test
    wb(1'b1, rac_pkg::IDX_RESET_ACTIONS, 8'h01, 1'b1, r);
    irq_event_i <= '1;
    @(posedge sys_clk_i);
    irq_event_i <= '0;
    e = {rac_pkg::MASK_REFS, rac_pkg::MASK_HIST, rac_pkg::MASK_DPLL, rac_pkg::MASK_SYNC,
      rac_pkg::MASK_SYS};
    #1 chk("monitor set", e, irq_monitor_o);
    wb(1'b1, rac_pkg::IDX_CLR_DPLL, 8'hff, 1'b0, r);
    #1 chk("sel off", e, irq_monitor_o);
    for (int g = 0; g < 10; g++)
    begin
      p = (g % 2) ? 8'haa : 8'h55;
      wb(1'b1, rac_pkg::IDX_CLR_SYS + 12'(g / 2), p, 1'b1, r);
      e[(g / 2) * 8 +: 8] = e[(g / 2) * 8 +: 8] & ~p;
      #1 chk("clear", e, irq_monitor_o);
    end
    @(posedge sys_clk_i);
    irq_event_i <= '1;
    @(posedge sys_clk_i);
    irq_event_i <= '0;
    wb(1'b0, rac_pkg::IDX_MON_BASE + 12'h2, 8'h00, 1'b1, r);
    chk("mon read", 40'(rac_pkg::MASK_DPLL), 40'(r));
    e = {rac_pkg::MASK_REFS, rac_pkg::MASK_HIST, rac_pkg::MASK_DPLL, rac_pkg::MASK_SYNC,
      rac_pkg::MASK_SYS};
    for (int g = 0; g < 5; g++)
    begin
      wb(1'b0, rac_pkg::IDX_MON_BASE + 12'(g), 8'h00, 1'b1, r);
      chk("mon group", 40'(e[g * 8 +: 8]), 40'(r));
    end
    // event and clear on one edge: the event must win
    irq_event_i.dpll <= 8'h01;
    wb(1'b1, rac_pkg::IDX_CLR_DPLL, 8'h01, 1'b1, r);
    irq_event_i <= '0;
    #1 chk("set wins", e, irq_monitor_o);
    // monitor row and spare index take no writes
    for (int k = 0; k < 2; k++)
    begin
      wb(1'b1, k ? rac_pkg::IDX_CLR_SPARE : rac_pkg::IDX_MON_BASE + 12'h2, 8'hff, 1'b1, r);
      #1 chk("ignored", e, irq_monitor_o);
    end
    wb(1'b1, rac_pkg::IDX_RESET_ACTIONS, 8'h02, 1'b1, r);
    #1 chk("clear all", 40'h0, irq_monitor_o);
    $display("irq done");
  endtask : t_irq
  task automatic t_wdog();
    logic [7:0] r;
    logic seen;
    int i;
    i = 0;
    while (watchdog_expired_o !== 1'b1 && i < 3 * WCYC)
    begin
      @(posedge sys_clk_i);
      i++;
    end
    if (watchdog_expired_o !== 1'b1)
    begin
      n_fail++;
      stop_test();
    end
    wb(1'b0, rac_pkg::IDX_MON_BASE + 12'h1, 8'h00, 1'b1, r);
    chk("expired", 40'h1, 40'(watchdog_expired_o));
    chk("wdog irq", 40'h1, 40'(r[rac_pkg::WDOG_IRQ_BIT]));
    wb(1'b0, rac_pkg::IDX_WDOG_STAT, 8'h00, 1'b1, r);
    chk("wdog stat", 40'h1, 40'(r));
    wb(1'b1, rac_pkg::IDX_CLR_SYNC, 8'h04, 1'b1, r);
    wb(1'b1, rac_pkg::IDX_RESET_ACTIONS, 8'h01, 1'b1, r);
    repeat (2) @(posedge sys_clk_i);
    #1 chk("restarted", 40'h0, 40'(watchdog_expired_o));
    wb(1'b0, rac_pkg::IDX_WDOG_STAT, 8'h00, 1'b1, r);
    chk("wdog stat low", 40'h0, 40'(r));
    seen = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      repeat (WCYC / 2)
      begin
        @(posedge sys_clk_i);
        seen = seen | watchdog_expired_o | irq_monitor_o.sync[rac_pkg::WDOG_IRQ_BIT];
      end
      wb(1'b1, rac_pkg::IDX_RESET_ACTIONS, 8'h01, 1'b1, r);
    end
    chk("no timeout", 40'h0, 40'(seen));
    $display("watchdog done");
  endtask : t_wdog
  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    t_actions();
    t_irq();
    t_wdog();
    stop_test();
  end
endmodule : tb
bind rac_ctrl rac_checker #(.WDOG_CYC(WDOG_CYC)) u_rac_checker (.*);
